// ### core/msb_monitor_ctrl.sv
// studio monitor channel: source interlock, button modes, setup, cue and talkback
// assumes one 10 MHz clock, synchronous panel inputs, async active-low reset
`timescale 1ns/1ps
`default_nettype none

// overview: panel buttons pass the debouncer, then one state register
// holds the captured straps, the run or setup phase, the hold and flash
// timers, per-button modes, stored selections and the lamp and route words
// every output changes one cycle after its cause (a debounced button or a mute request), never directly
// limitation: strap changes take effect only after the next reset
// trade-off: modes advance on release so the exit hold changes no mode
// hazard: button timing assumes the debounce window exceeds contact chatter

// What this block does
// - source buttons interlock unless mix mode applies
// - lit source lamp; program/audition green, externals red
// - enter setup after both held five seconds
// - setup lamps flash burst of mode number
// - setup press advances mode, wraps to one
// - both held two seconds leaves setup
// - modes are kept after leaving setup
// - source buttons: normal, on, off, mix
// - mix buttons may stay on together
// - cue and split buttons: normal, on, off
// - split works only with headphone cue
// - speaker cue routes cue channels to speakers
// - headphone cue routes cue channels to headphones
// - live mic lights mute, mutes speakers, closes contacts
// - talkback button routes speaker and headphone talkback per jumpers; global talkback needs no press
// - speaker talkback replaces source, muted with speakers
// - speaker talkback plus dim dims source instead
// - headphone dim dims headphone source under talkback
// - global talkback only with both mutes clear
// - jumper defaults: global off, spk on, dim on, hp off
// - identity link and jumpers read at configuration
module msb_monitor_ctrl #(
	parameter int unsigned ENTER_CYC    = msb_pkg::ENTER_CYC,
	parameter int unsigned EXIT_CYC     = msb_pkg::EXIT_CYC,
	parameter int unsigned DEBOUNCE_CYC = msb_pkg::DEBOUNCE_CYC,
	parameter int unsigned FLASH_CYC    = msb_pkg::FLASH_CYC
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	// front panel buttons, high while pressed
	input  wire msb_pkg::msb_btn_t  button_raw,
	// mute requests from the mic channels
	input  wire logic               studio_mute_req,
	input  wire logic               cr_mute_req,
	// straps
	input  wire msb_pkg::msb_opt_t  jumper_fitted,
	input  wire logic               channel_identity_link,
	// panel lamps
	output msb_pkg::msb_lamp_t      lamp,
	// audio switching controls
	output msb_pkg::msb_route_t     route,
	// status
	output logic                    setup_active,
	output logic                    channel_is_studio
);

	// whole state of the controller
	// one packed word keeps reset and update in a single place
	typedef struct packed {
		logic                         cfg_done;    // straps captured
		msb_pkg::msb_opt_t            opt;         // captured jumpers
		logic                         ident;       // captured identity
		msb_pkg::msb_phase_t          phase;       // run or setup
		logic                         wait_rel;    // hold done, await release
		logic                         combo_seen;  // both held since idle
		logic [msb_pkg::HOLD_W-1:0]   hold;        // hold timer
		logic [msb_pkg::FLASH_W-1:0]  tick;        // flash step timer
		logic [3:0]                   step;        // flash burst position
		logic [msb_pkg::NBTN-1:0]     prev;        // last debounced buttons
		logic [msb_pkg::NMODED-1:0][1:0] mode;     // per-button modes
		logic [msb_pkg::NSRC-1:0]     sel;         // stored source choice
		logic                         apf_spk;     // speaker cue toggle
		logic                         apf_hp;      // headphone cue toggle
		logic                         split;       // split toggle
		msb_pkg::msb_lamp_t           lamp;        // lamp register
		msb_pkg::msb_route_t          route;       // route register
	} msb_st_t;

	msb_st_t s_q;   // registered state
	msb_st_t s_d;   // next state

	// raw pins are never read past this point
	logic [msb_pkg::NBTN-1:0] db;   // debounced buttons

	// debounce every panel button before use
	// one window per button; talkback is debounced as well
	msb_debounce #(
		.W   (msb_pkg::NBTN),
		.CYC (DEBOUNCE_CYC)
	) u_debounce (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.raw     (button_raw),
		.clean   (db)
	);

	// highest mode code of a button
	// talkback has no mode and never reaches this
	function automatic logic [1:0] max_mode(input int unsigned i);
		max_mode = (i < msb_pkg::NSRC) ? msb_pkg::SRC_MAX : msb_pkg::AUX_MAX;
	endfunction

	// effective state of a moded button
	// forced modes override the stored choice; normal and mix follow it
	function automatic logic eff(input logic [1:0] m, input logic s);
		if (m == msb_pkg::MODE_ON) begin
			eff = 1'b1;
		end else if (m == msb_pkg::MODE_OFF) begin
			eff = 1'b0;
		end else begin
			eff = s;
		end
	endfunction

	// lamp lit within the burst: one on-step pair per mode number
	// code m lights m+1 even steps, then the burst rests dark to step 11
	function automatic logic flash_on(input logic [1:0] m, input logic [3:0] st);
		logic [3:0] len;
		len = {1'b0, ({1'b0, m} + 3'h1)} << 1;
		flash_on = (st < len) && !st[0];
	endfunction

	// scratch signals of the next-state logic
	// all are set at the top of the process or on every path
	logic                          both;     // program and audition held
	logic                          idle;     // no moded button held
	logic                          toggle;   // hold time reached
	logic [msb_pkg::HOLD_W-1:0]    hold_lim; // target of the hold timer
	logic [msb_pkg::NBTN-1:0]      rise;     // press edges
	logic [msb_pkg::NBTN-1:0]      fall;     // release edges
	logic [msb_pkg::NSRC-1:0]      src_eff;  // effective sources
	logic [msb_pkg::NMODED-1:0]    fl;       // flash pattern per button
	logic                          apfs_e;   // effective speaker cue
	logic                          apfh_e;   // effective headphone cue
	logic                          split_e;  // effective split
	logic                          mute;     // studio mute active
	logic                          tb;       // talkback pressed
	logic                          spk_tb;   // talkback to speakers
	logic                          glob;     // global talkback live
	msb_pkg::msb_opt_t             opt;      // options in use

	// next-state logic
	always_comb begin
		// untouched fields keep their registered value
		s_d    = s_q;
		both   = db[msb_pkg::B_PGM] & db[msb_pkg::B_AUD];
		idle   = ~|db[msb_pkg::NMODED-1:0];
		// edges come from debounced levels, so chatter cannot double a press
		rise   = db & ~s_q.prev;
		fall   = ~db & s_q.prev;
		toggle = 1'b0;
		s_d.prev = db;

		// straps are taken once, on the first edge after reset
		// later strap changes are ignored until the next reset
		if (!s_q.cfg_done) begin
			s_d.cfg_done = 1'b1;
			s_d.opt      = jumper_fitted;
			s_d.ident    = channel_identity_link;
		end

		// in setup, a two-button hold must not also count as single presses
		// cleared only once every moded button is up again
		if (both) begin
			s_d.combo_seen = 1'b1;
		end else if (idle) begin
			s_d.combo_seen = 1'b0;
		end

		// hold timer; entry and exit need different times
		// wait_rel stops one long hold from toggling twice
		if (s_q.phase == msb_pkg::MSB_SETUP) begin
			hold_lim = msb_pkg::HOLD_W'(EXIT_CYC - 1);
		end else begin
			hold_lim = msb_pkg::HOLD_W'(ENTER_CYC - 1);
		end
		if (!both) begin
			// any release restarts the hold from zero
			s_d.hold     = '0;
			s_d.wait_rel = 1'b0;
		end else if (!s_q.wait_rel) begin
			if (s_q.hold == hold_lim) begin
				toggle       = 1'b1;
				s_d.hold     = '0;
				s_d.wait_rel = 1'b1;
			end else begin
				s_d.hold = s_q.hold + 1'b1;
			end
		end

		// phase machine: run takes presses, setup edits modes
		case (s_q.phase)
			msb_pkg::MSB_RUN: begin
				if (toggle) begin
					// start every burst from its first flash
					s_d.phase = msb_pkg::MSB_SETUP;
					s_d.tick  = '0;
					s_d.step  = '0;
				end else begin
					// source buttons: pressing a normal one drops all others, a mix one drops only the non-mix ones
					// forced-on and forced-off buttons ignore presses here
					for (int unsigned i = 0; i < msb_pkg::NSRC; i++) begin
						if (rise[i] && s_q.mode[i] == msb_pkg::MODE_NORMAL) begin
							s_d.sel    = '0;
							s_d.sel[i] = 1'b1;
						end else if (rise[i] && s_q.mode[i] == msb_pkg::MODE_MIX) begin
							// keep only the other mix buttons alongside
							for (int unsigned j = 0; j < msb_pkg::NSRC; j++) begin
								s_d.sel[j] = s_d.sel[j] && s_q.mode[j] == msb_pkg::MODE_MIX;
							end
							s_d.sel[i] = 1'b1;
						end
					end
					// cue and split buttons toggle in normal mode only
					// a stored toggle survives a forced mode and returns with normal
					if (rise[msb_pkg::B_APFS] && s_q.mode[msb_pkg::B_APFS] == msb_pkg::MODE_NORMAL) begin
						s_d.apf_spk = !s_q.apf_spk;
					end
					if (rise[msb_pkg::B_APFH] && s_q.mode[msb_pkg::B_APFH] == msb_pkg::MODE_NORMAL) begin
						s_d.apf_hp = !s_q.apf_hp;
					end
					if (rise[msb_pkg::B_SPLIT] && s_q.mode[msb_pkg::B_SPLIT] == msb_pkg::MODE_NORMAL) begin
						s_d.split = !s_q.split;
					end
				end
			end
			msb_pkg::MSB_SETUP: begin
				// selection presses are ignored while in setup
				if (toggle) begin
					// modes are left as set; nothing is cleared here
					s_d.phase = msb_pkg::MSB_RUN;
				end else begin
					// flash step timer runs only in setup
					if (s_q.tick == msb_pkg::FLASH_W'(FLASH_CYC - 1)) begin
						s_d.tick = '0;
						if (s_q.step == msb_pkg::FLASH_LAST) begin
							s_d.step = '0;
						end else begin
							s_d.step = s_q.step + 1'b1;
						end
					end else begin
						s_d.tick = s_q.tick + 1'b1;
					end
					// advance on release so the exit hold changes nothing
					for (int unsigned i = 0; i < msb_pkg::NMODED; i++) begin
						if (fall[i] && !s_q.combo_seen) begin
							if (s_q.mode[i] == max_mode(i)) begin
								s_d.mode[i] = msb_pkg::MODE_NORMAL;
							end else begin
								s_d.mode[i] = s_q.mode[i] + 1'b1;
							end
						end
					end
				end
			end
			// unreachable with a one-bit phase; a safe landing only
			default: begin
				s_d.phase = msb_pkg::MSB_RUN;
			end
		endcase

		// effective selections from next stored state and modes
		// using the next state keeps lamps and routing in step
		for (int unsigned i = 0; i < msb_pkg::NSRC; i++) begin
			src_eff[i] = eff(s_d.mode[i], s_d.sel[i]);
		end
		apfs_e  = eff(s_d.mode[msb_pkg::B_APFS], s_d.apf_spk);
		apfh_e  = eff(s_d.mode[msb_pkg::B_APFH], s_d.apf_hp);
		split_e = eff(s_d.mode[msb_pkg::B_SPLIT], s_d.split) & apfh_e;

		// cue routing enables
		s_d.route.source    = src_eff;
		s_d.route.spk_pfl   = apfs_e;
		s_d.route.hp_pfl    = apfh_e;
		s_d.route.split_cue = split_e;

		// talkback and mutes use the captured options
		// the control room mute only gates global talkback
		opt  = s_d.opt;
		mute = studio_mute_req;
		tb   = db[msb_pkg::B_TB];
		spk_tb = tb & opt.speaker_talkback_option;
		glob = opt.global_talkback_option & !mute & !cr_mute_req;

		// speakers: muted by a live mic, talkback replaces or dims
		s_d.route.mic_live    = mute;
		s_d.route.spk_tb_on   = spk_tb & !mute;
		s_d.route.spk_src_on  = !mute && !(spk_tb && !opt.speaker_dim_option);
		s_d.route.spk_src_dim = spk_tb & opt.speaker_dim_option;

		// headphones: talkback follows the speaker option
		s_d.route.hp_tb_on   = spk_tb;
		s_d.route.hp_src_on  = !(spk_tb && !opt.headphone_dim_option);
		s_d.route.hp_src_dim = (spk_tb & opt.headphone_dim_option) | glob;
		s_d.route.global_tb  = glob;

		// lamps: mode bursts in setup, live selection otherwise
		// the mute lamp keeps following the mic even in setup
		for (int unsigned i = 0; i < msb_pkg::NMODED; i++) begin
			fl[i] = flash_on(s_d.mode[i], s_d.step);
		end
		s_d.lamp.mute = mute;
		if (s_d.phase == msb_pkg::MSB_SETUP) begin
			s_d.lamp.green   = fl[msb_pkg::B_AUD:msb_pkg::B_PGM];
			s_d.lamp.red     = fl[msb_pkg::B_EXT2:msb_pkg::B_EXT1];
			s_d.lamp.apf_spk = fl[msb_pkg::B_APFS];
			s_d.lamp.apf_hp  = fl[msb_pkg::B_APFH];
			s_d.lamp.split   = fl[msb_pkg::B_SPLIT];
		end else begin
			s_d.lamp.green   = src_eff[msb_pkg::B_AUD:msb_pkg::B_PGM];
			s_d.lamp.red     = src_eff[msb_pkg::B_EXT2:msb_pkg::B_EXT1];
			s_d.lamp.apf_spk = apfs_e;
			s_d.lamp.apf_hp  = apfh_e;
			s_d.lamp.split   = split_e;
		end
	end

	// state register; straps are not sampled here, only constants
	// options start at the shipped defaults until the first edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q       <= '0;
			s_q.opt   <= msb_pkg::OPT_DEFAULT;
			s_q.sel   <= msb_pkg::SEL_RST;
			s_q.phase <= msb_pkg::MSB_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	// a one-bit compare is the only logic after the register
	assign lamp              = s_q.lamp;
	assign route             = s_q.route;
	assign setup_active      = (s_q.phase == msb_pkg::MSB_SETUP);
	assign channel_is_studio = s_q.ident;

endmodule // msb_monitor_ctrl

`default_nettype wire

// ### include/msb_pkg.sv
// shared constants and carrier types for the studio monitor button controller
// assumes a single 10 MHz system clock; every time is converted here to cycles
package msb_pkg;

	// clock rate and times in their own units
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned ENTER_MS    = 5000;   // setup entry hold
	localparam int unsigned EXIT_MS     = 2000;   // setup exit hold
	localparam int unsigned DEBOUNCE_MS = 10;     // contact settle time
	localparam int unsigned FLASH_MS    = 200;    // half period of a flash
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;

	// derived cycle counts (least times, exact at this rate)
	localparam int unsigned ENTER_CYC    = ENTER_MS * CYC_PER_MS;
	localparam int unsigned EXIT_CYC     = EXIT_MS * CYC_PER_MS;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int unsigned FLASH_CYC    = FLASH_MS * CYC_PER_MS;

	// counter widths sized for the default counts
	localparam int unsigned HOLD_W  = 26;
	localparam int unsigned FLASH_W = 22;

	// button indices
	localparam int unsigned NSRC    = 4;
	localparam int unsigned NMODED  = 7;
	localparam int unsigned NBTN    = 8;
	localparam int unsigned B_PGM   = 0;
	localparam int unsigned B_AUD   = 1;
	localparam int unsigned B_EXT1  = 2;
	localparam int unsigned B_EXT2  = 3;
	localparam int unsigned B_APFS  = 4;
	localparam int unsigned B_APFH  = 5;
	localparam int unsigned B_SPLIT = 6;
	localparam int unsigned B_TB    = 7;

	// mode codes, stored as mode number minus one
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ON     = 2'h1;
	localparam logic [1:0] MODE_OFF    = 2'h2;
	localparam logic [1:0] MODE_MIX    = 2'h3;
	localparam logic [1:0] SRC_MAX     = 2'h3;
	localparam logic [1:0] AUX_MAX     = 2'h2;

	// flash burst: up to four flashes of two steps, then at least four dark steps
	localparam logic [3:0] FLASH_LAST = 4'hb;

	// values after reset
	localparam logic [3:0] SEL_RST = 4'h1;

	// run or setup
	typedef enum logic {MSB_RUN, MSB_SETUP} msb_phase_t;

	// debounced or raw front-panel buttons, high while pressed
	typedef struct packed {
		logic talkback;
		logic split;
		logic apf_hp;
		logic apf_spk;
		logic ext2;
		logic ext1;
		logic audition_bus_button;
		logic program_bus_button;
	} msb_btn_t;

	// option jumpers, high when fitted
	typedef struct packed {
		logic global_talkback_option;
		logic speaker_talkback_option;
		logic speaker_dim_option;
		logic headphone_dim_option;
	} msb_opt_t;

	// shipped jumper settings
	localparam msb_opt_t OPT_DEFAULT = 4'h6;

	// lamp drives, high for lit
	typedef struct packed {
		logic [1:0] green;
		logic [1:0] red;
		logic       apf_spk;
		logic       apf_hp;
		logic       split;
		logic       mute;
	} msb_lamp_t;

	// audio switching controls
	typedef struct packed {
		logic [3:0] source;
		logic       spk_pfl;
		logic       hp_pfl;
		logic       split_cue;
		logic       spk_src_on;
		logic       spk_src_dim;
		logic       spk_tb_on;
		logic       hp_src_on;
		logic       hp_src_dim;
		logic       hp_tb_on;
		logic       mic_live;
		logic       global_tb;
	} msb_route_t;

endpackage

// ### core/msb_debounce.sv
// per-bit debouncer for the front-panel buttons
// assumes raw inputs already synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none

module msb_debounce #(
	parameter int unsigned W   = 8,
	parameter int unsigned CYC = msb_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	// buttons
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] clean
);

	localparam int unsigned CW = $clog2(CYC + 1);

	// whole state: settled levels and per-bit disagreement counters
	typedef struct packed {
		logic [W-1:0]         clean;
		logic [W-1:0][CW-1:0] cnt;
	} msb_db_st_t;

	msb_db_st_t s_q;    // registered state
	msb_db_st_t s_d;    // next state
	logic [W-1:0]         clean_nx;
	logic [W-1:0][CW-1:0] cnt_nx;

	// each bit must disagree for a full window before it is accepted
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			clean_nx[i] = s_q.clean[i];
			cnt_nx[i]   = '0;
			if (raw[i] != s_q.clean[i]) begin
				if (s_q.cnt[i] == CW'(CYC - 1)) begin
					clean_nx[i] = raw[i];
				end else begin
					cnt_nx[i] = s_q.cnt[i] + 1'b1;
				end
			end
		end
	end

	// gather per-bit results
	always_comb begin
		s_d.clean = clean_nx;
		s_d.cnt   = cnt_nx;
	end

	// state register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign clean = s_q.clean;

endmodule // msb_debounce

`default_nettype wire

// ### tb/msb_panel_model.sv
// front panel contacts as the controller sees them
// assumes the bench moves press just after a falling edge
`timescale 1ns/1ps
`default_nettype none

module msb_panel_model (
	// clock
	input  wire logic              sys_clk,
	// finger on each button, high while held
	input  wire msb_pkg::msb_btn_t press,
	// contacts, with chatter
	output msb_pkg::msb_btn_t      button_raw
);
	logic [7:0]      held_q = 8'h00; // settled contact level
	logic [7:0][1:0] bnc_q  = '0;    // chatter steps left
	logic [7:0]      raw_w;

	// a change chatters for three cycles, no longer than the settle window
	always @(posedge sys_clk) begin
		for (int i = 0; i < 8; i++) begin
			if (press[i] != held_q[i]) begin
				held_q[i] <= press[i];
				bnc_q[i]  <= 2'h3;
			end else if (bnc_q[i] != 2'h0) begin
				bnc_q[i] <= bnc_q[i] - 2'h1;
			end
		end
	end

	// odd steps show the old level
	always_comb begin
		for (int j = 0; j < 8; j++) begin
			raw_w[j] = held_q[j] ^ bnc_q[j][0];
		end
	end
	assign button_raw = raw_w;
endmodule // msb_panel_model

`default_nettype wire

// ### tb/msb_monitor_ctrl_assertions.sv
// port checker for the monitor controller
// assumes the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module msb_monitor_ctrl_assertions (
	// clock and reset
	input wire logic                sys_clk,
	input wire logic                arst_n,
	// inputs
	input wire msb_pkg::msb_btn_t   button_raw,
	input wire logic                studio_mute_req,
	input wire logic                cr_mute_req,
	// outputs
	input wire msb_pkg::msb_lamp_t  lamp,
	input wire msb_pkg::msb_route_t route,
	input wire logic                setup_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// both hold buttons were down well before the change
	sequence held_before;
		$past(button_raw.program_bus_button && button_raw.audition_bus_button, 12);
	endsequence

	AST_MIC_LIVE: assert property ($past(arst_n) |-> route.mic_live == $past(studio_mute_req))
		else $error("mic live not following studio mute");
	AST_MUTE_LAMP: assert property (lamp.mute == route.mic_live)
		else $error("mute lamp differs from mic live");
	AST_SPK_MUTED: assert property (route.mic_live |-> !route.spk_tb_on && !route.spk_src_on)
		else $error("speaker not muted");
	AST_GLOBAL: assert property ($past(arst_n) && route.global_tb |->
		!$past(cr_mute_req) && !$past(studio_mute_req))
		else $error("global talkback while muted");
	AST_SPLIT_DEP: assert property (route.split_cue |-> route.hp_pfl)
		else $error("split without headphone cue");
	AST_SPK_TB: assert property (route.spk_tb_on |-> route.spk_src_dim || !route.spk_src_on)
		else $error("speaker source at full level under talkback");
	AST_HP_TB: assert property (route.hp_tb_on |-> route.hp_src_dim || !route.hp_src_on)
		else $error("headphone source at full level under talkback");
	AST_SETUP_ENTER: assert property ($rose(setup_active) |-> held_before)
		else $error("setup entered without hold");
	AST_SETUP_EXIT: assert property ($fell(setup_active) |-> held_before)
		else $error("setup left without hold");
	AST_LAMP_SRC: assert property (!setup_active && !$past(setup_active) |->
		lamp.green == route.source[1:0] && lamp.red == route.source[3:2])
		else $error("source lamps differ from source");
endmodule // msb_monitor_ctrl_assertions

bind msb_monitor_ctrl msb_monitor_ctrl_assertions u_chk (
	.sys_clk(sys_clk), .arst_n(arst_n), .button_raw(button_raw),
	.studio_mute_req(studio_mute_req), .cr_mute_req(cr_mute_req),
	.lamp(lamp), .route(route), .setup_active(setup_active)
);

`default_nettype wire

// ### tb/tb_msb_monitor_ctrl.sv
// bench for the monitor controller with short counts
// assumes the panel model between bench and button pins
`timescale 1ns/1ps
`default_nettype none

module tb_msb_monitor_ctrl;
	localparam int DB = 3; // settle cycles
	localparam int FL = 4; // flash step cycles
	localparam int W  = DB + 12; // settle plus chatter and latency

	logic                sys_clk = 1'b0;
	logic                arst_n = 1'b0;
	msb_pkg::msb_btn_t   press = 8'h00;
	msb_pkg::msb_btn_t   button_raw;
	logic                studio_mute_req = 1'b0;
	logic                cr_mute_req = 1'b0;
	logic                ident_link = 1'b1;
	msb_pkg::msb_opt_t   jumper_fitted = msb_pkg::OPT_DEFAULT;
	msb_pkg::msb_lamp_t  lamp;
	msb_pkg::msb_route_t route;
	logic                setup_active;
	logic                channel_is_studio;
	int                  n_fail = 0;
	int                  compares = 0;

	always #50 sys_clk = ~sys_clk;

	msb_panel_model panel (.sys_clk(sys_clk), .press(press), .button_raw(button_raw));

	msb_monitor_ctrl #(.ENTER_CYC(40), .EXIT_CYC(20), .DEBOUNCE_CYC(DB), .FLASH_CYC(FL)) DUT (
		.sys_clk(sys_clk), .arst_n(arst_n), .button_raw(button_raw),
		.studio_mute_req(studio_mute_req), .cr_mute_req(cr_mute_req),
		.jumper_fitted(jumper_fitted), .channel_identity_link(ident_link),
		.lamp(lamp), .route(route), .setup_active(setup_active),
		.channel_is_studio(channel_is_studio)
	);

	task automatic summarize;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// gain and talkback switches, speaker first
	function automatic logic [7:0] gains(input msb_pkg::msb_route_t r);
		return {r.spk_src_on, r.spk_src_dim, r.spk_tb_on, r.hp_src_on,
			r.hp_src_dim, r.hp_tb_on, r.mic_live, r.global_tb};
	endfunction

	// source switches beside the four source lamps
	function automatic logic [7:0] srcs();
		return {route.source, lamp.green, lamp.red};
	endfunction

	task automatic tap(input logic [7:0] b);
		press = b;
		cyc(W);
		press = 8'h00;
		cyc(W);
	endtask

	// hold both until setup flips, never sooner than the hold time
	task automatic hold_until(input logic lvl, input int least);
		int i;
		press = 8'h03;
		for (i = 0; i < 200 && setup_active !== lvl; i++) cyc(1);
		chk({7'h00, setup_active}, {7'h00, lvl});
		chk({7'h00, i >= least}, 8'h01);
		if (setup_active !== lvl) summarize();
		press = 8'h00;
		cyc(W);
	endtask

	// rising edges over one whole burst of twelve steps
	task automatic flashes(input int b, input int n);
		int c;
		logic p;
		c = 0;
		p = lamp[b];
		for (int k = 0; k < 12 * FL; k++) begin
			cyc(1);
			if (lamp[b] && !p) c++;
			p = lamp[b];
		end
		chk(8'(c), 8'(n));
	endtask

	task automatic t_reset;
		chk(srcs(), 8'h14);
		chk(gains(route), 8'h90);
		chk({6'h00, setup_active, channel_is_studio}, 8'h01);
	endtask

	task automatic t_select;
		logic [7:0] b[4] = '{8'h04, 8'h08, 8'h02, 8'h01};
		logic [7:0] e[4] = '{8'h41, 8'h82, 8'h28, 8'h14};
		for (int k = 0; k < 4; k++) begin
			tap(b[k]);
			chk(srcs(), e[k]);
		end
		// a one-cycle press with chatter must not select anything
		press = 8'h08;
		cyc(1);
		press = 8'h00;
		cyc(W);
		chk(srcs(), 8'h14);
	endtask

	task automatic t_talk;
		press = 8'h80;
		cyc(W);
		chk(gains(route), 8'he4);
		studio_mute_req = 1'b1;
		cyc(3);
		chk(gains(route), 8'h46);
		chk({7'h00, lamp.mute}, 8'h01);
		studio_mute_req = 1'b0;
		press = 8'h00;
		cyc(W);
		chk(gains(route), 8'h90);
	endtask

	task automatic t_cue;
		logic [7:0] b[5] = '{8'h20, 8'h40, 8'h20, 8'h10, 8'h10};
		logic [2:0] e[5] = '{3'h2, 3'h3, 3'h0, 3'h4, 3'h0};
		for (int k = 0; k < 5; k++) begin
			tap(b[k]);
			chk({2'h0, route.spk_pfl, route.hp_pfl, route.split_cue,
				lamp.apf_spk, lamp.apf_hp, lamp.split}, {2'h0, e[k], e[k]});
		end
	endtask

	task automatic t_setup;
		hold_until(1'b1, 40);
		tap(8'h04);
		repeat (3) tap(8'h08);
		repeat (3) tap(8'h40);
		repeat (2) tap(8'h02);
		chk({4'h0, route.source}, 8'h04);
		flashes(4, 2);
		flashes(7, 3);
		flashes(5, 4);
		flashes(1, 1);
	endtask

	task automatic t_modes;
		hold_until(1'b0, 20);
		tap(8'h01);
		chk(srcs(), 8'h55);
		tap(8'h08);
		chk(srcs(), 8'hc3);
		tap(8'h01);
		chk(srcs(), 8'h55);
		tap(8'h02);
		chk(srcs(), 8'h55);
	endtask

	task automatic t_global;
		arst_n = 1'b0;
		jumper_fitted = 4'h8;
		ident_link = 1'b0;
		cyc(2);
		arst_n = 1'b1;
		cyc(4);
		chk(gains(route), 8'h99);
		// straps moved after capture must change nothing
		jumper_fitted = msb_pkg::OPT_DEFAULT;
		ident_link = 1'b1;
		press = 8'h80;
		cyc(W);
		chk(gains(route), 8'h99);
		chk({7'h00, channel_is_studio}, 8'h00);
		press = 8'h00;
		cr_mute_req = 1'b1;
		cyc(3);
		chk(gains(route), 8'h90);
		cr_mute_req = 1'b0;
	endtask

	initial begin
		cyc(8);
		arst_n = 1'b1;
		cyc(4);
		t_reset();
		t_select();
		t_talk();
		t_cue();
		t_setup();
		t_modes();
		t_global();
		summarize();
	end
endmodule // tb_msb_monitor_ctrl

`default_nettype wire
